// ---- verilog/ppc_ctrl.v ----
/*
  Escape command handler for proximity card polling: parses command
  frames from the host, keeps the polling setting and card type
  parameter, runs automatic and manual polls and answers each recognised frame.
  Assumes a byte stream in with a frame end strobe, a response
  consumer that takes one byte per RSP_VALID cycle, and a radio
  front end answering poll requests with a done pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ppc_map.vh"
module ppc_ctrl (
  input wire CLK,
  input wire RST_B,
  input wire CMD_VALID,
  input wire [7:0] CMD_BYTE,
  input wire CMD_END,
  output reg RSP_VALID,
  output reg [7:0] RSP_BYTE,
  output reg RSP_LAST,
  input wire EXCLUSIVE_MODE,
  input wire CONTACT_PRESENT,
  output reg POLL_REQ,
  output reg POLL_TYPE_A,
  output reg POLL_TYPE_B,
  output reg POLL_L4,
  input wire POLL_DONE,
  input wire POLL_FOUND,
  input wire CARD_ACTIVE,
  output reg FIELD_ON,
  output reg CARD_PRESENT
);
  // ----------------------------------------
  // States and derived counts
  // ----------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_MPOLL = 2'h1;
  localparam ST_SEND = 2'h2;
  localparam [23:0] MS_CYC = `PPC_MS_TICK;
  localparam [11:0] IVL0 = `PPC_IVL0_MS;
  localparam [11:0] IVL1 = `PPC_IVL1_MS;
  localparam [11:0] IVL2 = `PPC_IVL2_MS;
  localparam [11:0] IVL3 = `PPC_IVL3_MS;

  reg [7:0] poll_set_q;
  reg [7:0] ctype_q;
  reg [7:0] hdr_q [0:5];
  reg [2:0] cnt_q;
  reg [1:0] st_q;
  reg [2:0] rd_q;
  reg send_q;
  reg [7:0] rsp_data_q;
  reg [23:0] ms_q;
  reg [11:0] ivl_q;
  reg busy_q;
  reg manual_q;
  reg sync1_q, sync2_q, sync3_q;
  reg contact_q;
  reg wr_q;
  reg [2:0] wa_q;
  reg [7:0] wd_q;
  wire [7:0] mem_rd;
  integer i;

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  wire hdr_ok = hdr_q[0] == `PPC_CLA_CMD && hdr_q[1] == `PPC_INS && hdr_q[2] == `PPC_P1;
  wire is_poll_wr = hdr_ok && hdr_q[3] == `PPC_P2_POLL && hdr_q[4] == `PPC_LEN_ONE
    && cnt_q == 3'd6;
  wire is_poll_rd = hdr_ok && hdr_q[3] == `PPC_P2_POLL && hdr_q[4] == `PPC_LEN_ZERO
    && cnt_q == 3'd5;
  wire is_manual = hdr_ok && hdr_q[3] == `PPC_P2_MANUAL && hdr_q[4] == `PPC_LEN_ONE
    && hdr_q[5] == `PPC_MANUAL_ARG && cnt_q == 3'd6;
  wire is_ct_wr = hdr_ok && hdr_q[3] == `PPC_P2_CTYPE && hdr_q[4] == `PPC_LEN_ONE
    && cnt_q == 3'd6;
  wire is_ct_rd = hdr_ok && hdr_q[3] == `PPC_P2_CTYPE && hdr_q[4] == `PPC_LEN_ZERO
    && cnt_q == 3'd5;
  wire frame_go = CMD_END && st_q == ST_IDLE;
  wire excl_block = EXCLUSIVE_MODE && contact_q;
  wire auto_en = poll_set_q[`PPC_BIT_AUTO] && !excl_block;

  // ----------------------------------------
  // Contact card detect synchroniser
  // ----------------------------------------
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
      contact_q <= 1'b0;
    end else begin
      sync1_q <= CONTACT_PRESENT;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        contact_q <= sync3_q;
      end
    end
  end

  // ----------------------------------------
  // Interval timer
  // ----------------------------------------
  reg [11:0] ivl_lim;
  always @* begin
    case (poll_set_q[`PPC_BIT_IVL_HI:`PPC_BIT_IVL_LO])
      2'b00: ivl_lim = IVL0;
      2'b01: ivl_lim = IVL1;
      2'b10: ivl_lim = IVL2;
      default: ivl_lim = IVL3;
    endcase
  end
  wire ms_tick = ms_q == MS_CYC - 24'h000001;
  wire ivl_due = ms_tick && ivl_q >= ivl_lim - 12'h001;

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ms_q <= 24'h000000;
      ivl_q <= 12'h000;
    end else begin
      ms_q <= ms_tick ? 24'h000000 : ms_q + 24'h000001;
      if (ivl_due || !auto_en) begin
        ivl_q <= 12'h000;
      end else if (ms_tick) begin
        ivl_q <= ivl_q + 12'h001;
      end
    end
  end

  // ----------------------------------------
  // Main control
  // ----------------------------------------
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      poll_set_q <= `PPC_POLL_RST;
      ctype_q <= `PPC_CTYPE_RST;
      for (i = 0; i < 6; i = i + 1) begin
        hdr_q[i] <= 8'h00;
      end
      cnt_q <= 3'h0;
      st_q <= ST_IDLE;
      rd_q <= 3'h0;
      send_q <= 1'b0;
      rsp_data_q <= 8'h00;
      busy_q <= 1'b0;
      manual_q <= 1'b0;
      POLL_REQ <= 1'b0;
      CARD_PRESENT <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_BYTE <= 8'h00;
      RSP_LAST <= 1'b0;
    end else begin
      POLL_REQ <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_LAST <= 1'b0;
      if (CMD_VALID && st_q == ST_IDLE && !CMD_END) begin
        if (cnt_q < 3'd6) begin
          hdr_q[cnt_q] <= CMD_BYTE;
        end
        if (cnt_q != 3'd7) begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
      if (POLL_DONE && busy_q) begin
        busy_q <= 1'b0;
        CARD_PRESENT <= POLL_FOUND;
      end
      if (ivl_due && auto_en && !busy_q) begin
        POLL_REQ <= 1'b1;
        busy_q <= 1'b1;
      end
      case (st_q)
        ST_IDLE: begin
          if (frame_go) begin
            cnt_q <= 3'h0;
            if (is_poll_wr) begin
              poll_set_q <= hdr_q[5];
              rsp_data_q <= hdr_q[5];
              st_q <= ST_SEND;
            end else if (is_poll_rd) begin
              rsp_data_q <= poll_set_q;
              st_q <= ST_SEND;
            end else if (is_ct_wr) begin
              ctype_q <= hdr_q[5];
              rsp_data_q <= hdr_q[5];
              st_q <= ST_SEND;
            end else if (is_ct_rd) begin
              rsp_data_q <= ctype_q;
              st_q <= ST_SEND;
            end else if (is_manual) begin
              manual_q <= 1'b1;
              st_q <= ST_MPOLL;
            end
          end
        end
        ST_MPOLL: begin
          if (manual_q && !busy_q && !(ivl_due && auto_en)) begin
            POLL_REQ <= 1'b1;
            busy_q <= 1'b1;
            manual_q <= 1'b0;
          end else if (!manual_q && POLL_DONE && busy_q) begin
            rsp_data_q <= POLL_FOUND ? `PPC_ST_FOUND : `PPC_ST_NONE;
            st_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          send_q <= 1'b1;
          rd_q <= rd_q + 3'h1;
          if (send_q) begin
            RSP_VALID <= 1'b1;
            RSP_BYTE <= rd_q == 3'h6 ? rsp_data_q : mem_rd;
            if (rd_q == 3'h6) begin
              RSP_LAST <= 1'b1;
              send_q <= 1'b0;
              rd_q <= 3'h0;
              st_q <= ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Response header image
  // ----------------------------------------
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wr_q <= 1'b1;
      wa_q <= 3'h0;
      wd_q <= `PPC_CLA_RSP;
    end else if (wr_q) begin
      wa_q <= wa_q + 3'h1;
      wd_q <= wa_q == 3'h3 ? `PPC_LEN_ONE : 8'h00;
      wr_q <= wa_q != 3'h4;
    end
  end

  ppc_rsp_mem u_mem (
    .clk(CLK),
    .we(wr_q),
    .waddr(wa_q),
    .wdata(wd_q),
    .raddr(rd_q),
    .rdata(mem_rd)
  );

  // ----------------------------------------
  // Radio front end controls
  // ----------------------------------------
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      FIELD_ON <= 1'b1;
      POLL_TYPE_A <= 1'b1;
      POLL_TYPE_B <= 1'b1;
      POLL_L4 <= 1'b1;
    end else begin
      POLL_TYPE_A <= ctype_q[`PPC_BIT_TYPE_A];
      POLL_TYPE_B <= ctype_q[`PPC_BIT_TYPE_B];
      POLL_L4 <= poll_set_q[`PPC_BIT_L4];
      if (excl_block) begin
        FIELD_ON <= 1'b0;
      end else if (busy_q) begin
        FIELD_ON <= 1'b1;
      end else if (!CARD_PRESENT) begin
        FIELD_ON <= !poll_set_q[`PPC_BIT_OFF_NONE];
      end else begin
        FIELD_ON <= CARD_ACTIVE || !poll_set_q[`PPC_BIT_OFF_IDLE];
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/ppc_map.vh ----
/*
  Constants for the proximity polling command handler: frame bytes,
  setting field positions, reset values and poll interval counts.
  Assumes a 50 MHz system clock.
*/
`ifndef PPC_MAP_VH
`define PPC_MAP_VH

`define PPC_CLA_CMD 8'hE0
`define PPC_CLA_RSP 8'hE1
`define PPC_INS 8'h00
`define PPC_P1 8'h00
`define PPC_P2_POLL 8'h23
`define PPC_P2_MANUAL 8'h22
`define PPC_P2_CTYPE 8'h20
`define PPC_LEN_ONE 8'h01
`define PPC_LEN_ZERO 8'h00
`define PPC_MANUAL_ARG 8'h0A
`define PPC_ST_FOUND 8'h00
`define PPC_ST_NONE 8'hFF

`define PPC_POLL_RST 8'h8F
`define PPC_CTYPE_RST 8'h03
`define PPC_BIT_AUTO 0
`define PPC_BIT_OFF_NONE 1
`define PPC_BIT_OFF_IDLE 2
`define PPC_BIT_IVL_LO 4
`define PPC_BIT_IVL_HI 5
`define PPC_BIT_L4 7
`define PPC_BIT_TYPE_A 0
`define PPC_BIT_TYPE_B 1

`define PPC_CLK_HZ 32'h02FAF080
`define PPC_MS_TICK 24'h00C350
`define PPC_IVL0_MS 12'h0FA
`define PPC_IVL1_MS 12'h1F4
`define PPC_IVL2_MS 12'h3E8
`define PPC_IVL3_MS 12'h9C4
`define PPC_RSP_LEN 6

`endif

// ---- verilog/ppc_rsp_mem.v ----
/*
  Eight-byte response buffer with registered read data.
  Assumes writer and reader share the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ppc_rsp_mem (
  input wire clk,
  input wire we,
  input wire [2:0] waddr,
  input wire [7:0] wdata,
  input wire [2:0] raddr,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:7];
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ---- testbench/ppc_assertions.sv ----
/* Port checker for the polling command handler.
   Assumes one clock and a bind onto ppc_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module ppc_chk (
  input wire CLK,
  input wire RST_B,
  input wire RSP_VALID,
  input wire [7:0] RSP_BYTE,
  input wire RSP_LAST,
  input wire POLL_REQ,
  input wire POLL_L4,
  input wire POLL_DONE,
  input wire POLL_FOUND,
  input wire FIELD_ON,
  input wire CARD_PRESENT
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_len; $rose(RSP_VALID) |-> RSP_VALID [*6] ##1 !RSP_VALID; endproperty
  property p_hdr; $rose(RSP_VALID) |-> RSP_BYTE == 8'hE1 ##1 (RSP_BYTE == 8'h00) [*3]
    ##1 RSP_BYTE == 8'h01; endproperty
  property p_last; $rose(RSP_VALID) |-> !RSP_LAST [*5] ##1 RSP_LAST; endproperty
  property p_req; POLL_REQ |=> !POLL_REQ; endproperty
  property p_busy; POLL_REQ |=> FIELD_ON; endproperty
  property p_card; POLL_DONE |=> CARD_PRESENT == $past(POLL_FOUND); endproperty
  property p_chg; $changed(CARD_PRESENT) |-> $past(POLL_DONE); endproperty
  property p_rst; $rose(RST_B) |-> POLL_L4 && FIELD_ON && !CARD_PRESENT; endproperty
  a_len: assert property (p_len) else $error("response length wrong");
  a_hdr: assert property (p_hdr) else $error("response header wrong");
  a_last: assert property (p_last) else $error("last flag misplaced");
  a_req: assert property (p_req) else $error("poll request too long");
  a_busy: assert property (p_busy) else $error("field off during poll");
  a_card: assert property (p_card) else $error("card flag wrong");
  a_chg: assert property (p_chg) else $error("card flag moved alone");
  a_rst: assert property (p_rst) else $error("reset outputs wrong");
  c_rsp: cover property ($rose(RSP_VALID));
  c_fnd: cover property (POLL_DONE && POLL_FOUND);
  c_off: cover property (POLL_DONE && !POLL_FOUND ##2 !FIELD_ON);
endmodule
bind ppc_ctrl ppc_chk u_chk (.CLK(CLK), .RST_B(RST_B), .RSP_VALID(RSP_VALID),
  .RSP_BYTE(RSP_BYTE), .RSP_LAST(RSP_LAST), .POLL_REQ(POLL_REQ), .POLL_L4(POLL_L4),
  .POLL_DONE(POLL_DONE), .POLL_FOUND(POLL_FOUND), .FIELD_ON(FIELD_ON),
  .CARD_PRESENT(CARD_PRESENT));
`default_nettype wire

// ---- testbench/ppc_radio.sv ----
/* Radio front end model: answers each poll request after a few cycles.
   Assumes the bench sets found_i before the request. */
`timescale 1ns/1ps
`default_nettype none
module ppc_radio (
  input wire CLK,
  input wire RST_B,
  input wire POLL_REQ,
  input wire found_i,
  output logic POLL_DONE,
  output logic POLL_FOUND
);
  // ----------------------------------------
  // Poll answer
  // ----------------------------------------
  logic [2:0] cnt_q;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cnt_q <= 3'h0;
      POLL_DONE <= 1'b0;
      POLL_FOUND <= 1'b0;
    end else begin
      POLL_DONE <= (cnt_q == 3'h1);
      POLL_FOUND <= (cnt_q == 3'h1) ? found_i : ~POLL_FOUND;
      if (POLL_REQ)
        cnt_q <= 3'h4;
      else if (cnt_q != 3'h0)
        cnt_q <= cnt_q - 3'h1;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/picc_polling_control_tb_top.sv ----
/* Self-checking bench for the polling command handler.
   Assumes the radio model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module picc_polling_control_tb_top;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic CMD_VALID = 1'b0;
  logic [7:0] CMD_BYTE = 8'h00;
  logic CMD_END = 1'b0;
  logic EXCLUSIVE_MODE = 1'b0;
  logic CONTACT_PRESENT = 1'b0;
  logic CARD_ACTIVE = 1'b0;
  logic found = 1'b0;
  wire RSP_VALID, RSP_LAST, POLL_REQ, POLL_TYPE_A, POLL_TYPE_B, POLL_L4;
  wire POLL_DONE, POLL_FOUND, FIELD_ON, CARD_PRESENT;
  wire [7:0] RSP_BYTE;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rows [0:5] = '{32'h2301_3636, 32'h2300_0036, 32'h2301_CECE,
    32'h2001_FEFE, 32'h2000_00FE, 32'h2001_0101};
  ppc_ctrl u_dut (.CLK(CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD_BYTE(CMD_BYTE),
    .CMD_END(CMD_END), .RSP_VALID(RSP_VALID), .RSP_BYTE(RSP_BYTE), .RSP_LAST(RSP_LAST),
    .EXCLUSIVE_MODE(EXCLUSIVE_MODE), .CONTACT_PRESENT(CONTACT_PRESENT),
    .POLL_REQ(POLL_REQ), .POLL_TYPE_A(POLL_TYPE_A), .POLL_TYPE_B(POLL_TYPE_B),
    .POLL_L4(POLL_L4), .POLL_DONE(POLL_DONE), .POLL_FOUND(POLL_FOUND),
    .CARD_ACTIVE(CARD_ACTIVE), .FIELD_ON(FIELD_ON), .CARD_PRESENT(CARD_PRESENT));
  ppc_radio u_radio (.CLK(CLK), .RST_B(RST_B), .POLL_REQ(POLL_REQ), .found_i(found),
    .POLL_DONE(POLL_DONE), .POLL_FOUND(POLL_FOUND));
  initial begin
    forever #10 CLK = ~CLK;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic flag(input logic seen, input logic exp, input string what);
    chk({7'h00, seen}, {7'h00, exp}, what);
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge CLK);
      #1;
    end
  endtask
  task automatic send(input logic [7:0] p2, input logic [7:0] lc, input logic [7:0] d);
    logic [7:0] f [0:5];
    f = '{8'hE0, 8'h00, 8'h00, p2, lc, d};
    for (int i = 0; i < 5 + int'(lc != 8'h00); i++) begin
      step(1);
      CMD_VALID = 1'b1;
      CMD_BYTE = f[i];
    end
    step(1);
    CMD_VALID = 1'b0;
    CMD_BYTE = ~CMD_BYTE;
    CMD_END = 1'b1;
    step(1);
    CMD_END = 1'b0;
  endtask
  task automatic rsp(input logic [7:0] p2, lc, d, exp);
    logic [7:0] e [0:5];
    int w;
    e = '{8'hE1, 8'h00, 8'h00, 8'h00, 8'h01, exp};
    w = 0;
    send(p2, lc, d);
    while (RSP_VALID !== 1'b1 && w < 40) begin
      step(1);
      w++;
    end
    for (int i = 0; i < 6; i++) begin
      chk(RSP_BYTE, e[i], "response byte");
      flag(RSP_VALID, 1'b1, "response valid");
      flag(RSP_LAST, i == 5, "response last");
      step(1);
    end
  endtask
  task end_sim();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    step(3);
    RST_B = 1'b1;
    step(8);
    chk({5'h00, POLL_L4, POLL_TYPE_B, POLL_TYPE_A}, 8'h07, "reset outs");
    rsp(8'h23, 8'h00, 8'h00, 8'h8F);
    rsp(8'h20, 8'h00, 8'h00, 8'h03);
    for (int i = 0; i < 6; i++) begin
      rsp(rows[i][31:24], rows[i][23:16], rows[i][15:8], rows[i][7:0]);
    end
    chk({5'h00, POLL_L4, POLL_TYPE_B, POLL_TYPE_A}, 8'h05, "config outs");
    found = 1'b1;
    CARD_ACTIVE = 1'b1;
    rsp(8'h22, 8'h01, 8'h0A, 8'h00);
    flag(CARD_PRESENT, 1'b1, "card found");
    flag(FIELD_ON, 1'b1, "field active card");
    EXCLUSIVE_MODE = 1'b1;
    CONTACT_PRESENT = 1'b1;
    step(10);
    flag(FIELD_ON, 1'b0, "field exclusive");
    CONTACT_PRESENT = 1'b0;
    step(10);
    flag(FIELD_ON, 1'b1, "field restored");
    CARD_ACTIVE = 1'b0;
    step(3);
    flag(FIELD_ON, 1'b0, "field inactive card");
    found = 1'b0;
    rsp(8'h23, 8'h01, 8'h08, 8'h08);
    rsp(8'h22, 8'h01, 8'h0A, 8'hFF);
    flag(FIELD_ON, 1'b1, "field kept on");
    flag(CARD_PRESENT, 1'b0, "card gone");
    rsp(8'h23, 8'h01, 8'h02, 8'h02);
    rsp(8'h22, 8'h01, 8'h0A, 8'hFF);
    flag(FIELD_ON, 1'b0, "field off no card");
    send(8'h23, 8'h02, 8'h55);
    repeat (30) begin
      step(1);
      flag(RSP_VALID, 1'b0, "bad frame answer");
    end
    rsp(8'h23, 8'h00, 8'h00, 8'h02);
    RST_B = 1'b0;
    step(3);
    chk({5'h00, POLL_L4, POLL_TYPE_B, POLL_TYPE_A}, 8'h07, "mid reset outs");
    flag(RSP_VALID, 1'b0, "mid reset answer");
    RST_B = 1'b1;
    step(8);
    rsp(8'h23, 8'h00, 8'h00, 8'h8F);
    rsp(8'h20, 8'h00, 8'h00, 8'h03);
    end_sim();
  end
endmodule
`default_nettype wire
